// >>> rtl/pulse_count_pkg.sv
// Constants and carrier types for the single-wire pulse-count current setter.
// Assumes a 100 MHz system clock; times are given in nanoseconds.
package pulse_count_pkg;

	localparam int unsigned CLK_PERIOD_NS   = 10;
	localparam int unsigned LATCH_TIME_NS   = 500000;
	localparam int unsigned OFF_TIME_NS     = 500000;
	// Longest times round down to whole cycles.
	localparam int unsigned LATCH_CYCLES    = LATCH_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned OFF_CYCLES      = OFF_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned CODE_W          = 6;
	localparam int unsigned LEVELS          = 32;
	localparam int unsigned NUM_SINKS       = 3;
	localparam int unsigned TIMER_W         = 20;
	localparam logic [5:0]  CODE_RESET      = 6'h00;
	localparam logic [5:0]  CODE_FIRST      = 6'h01;
	localparam logic [5:0]  CODE_LAST       = 6'h20;
	localparam int unsigned CURRENT_W       = 9;

	typedef enum logic [1:0] {
		ST_SHUTDOWN = 2'b00,
		ST_BURST    = 2'b01,
		ST_ACTIVE   = 2'b11
	} link_state_type;

	// Drive setting shared by all sinks; current in units of 0.1 mA.
	typedef struct packed {
		logic                 enable;
		logic [CODE_W-1:0]    code;
		logic [CURRENT_W-1:0] current;
	} sink_drive_type;

endpackage

// >>> rtl/current_table.sv
// Code to sink-current lookup, registered output, units of 0.1 mA.
// Assumes codes 1..32; any other code gives zero current.
`timescale 1ns/10ps
module current_table
	import pulse_count_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic [CODE_W-1:0]    code,
	output      logic [CURRENT_W-1:0] current_r
);
	import pulse_count_pkg::*;

	logic [CURRENT_W-1:0] current_nxt;

	always_comb
	begin
		case (code)
			6'h01: current_nxt = 9'd302;
			6'h02: current_nxt = 9'd292;
			6'h03: current_nxt = 9'd283;
			6'h04: current_nxt = 9'd273;
			6'h05: current_nxt = 9'd263;
			6'h06: current_nxt = 9'd253;
			6'h07: current_nxt = 9'd244;
			6'h08: current_nxt = 9'd234;
			6'h09: current_nxt = 9'd224;
			6'h0a: current_nxt = 9'd214;
			6'h0b: current_nxt = 9'd205;
			6'h0c: current_nxt = 9'd195;
			6'h0d: current_nxt = 9'd185;
			6'h0e: current_nxt = 9'd175;
			6'h0f: current_nxt = 9'd166;
			6'h10: current_nxt = 9'd156;
			6'h11: current_nxt = 9'd146;
			6'h12: current_nxt = 9'd136;
			6'h13: current_nxt = 9'd127;
			6'h14: current_nxt = 9'd117;
			6'h15: current_nxt = 9'd107;
			6'h16: current_nxt = 9'd97;
			6'h17: current_nxt = 9'd88;
			6'h18: current_nxt = 9'd78;
			6'h19: current_nxt = 9'd68;
			6'h1a: current_nxt = 9'd58;
			6'h1b: current_nxt = 9'd49;
			6'h1c: current_nxt = 9'd39;
			6'h1d: current_nxt = 9'd29;
			6'h1e: current_nxt = 9'd19;
			6'h1f: current_nxt = 9'd10;
			6'h20: current_nxt = 9'd5;
			default: current_nxt = 9'd0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		current_r <= current_nxt;
	end

endmodule

// >>> rtl/pulse_count_led_current_set.sv
// Single-wire edge-counting decoder that sets three matched LED current sinks.
// Assumes the enable/data pin is asynchronous to clk and is synchronised here.
// Overview of operation
// - Count rising edges into data register.
// - After latch timeout, apply code to sinks.
// - Low beyond off timeout: shutdown, clear register.
// - Shutdown switches all three sinks off.
// - First edge from shutdown gives code one.
// - Each further edge advances code by one; after code 32 it wraps to one.
// - Code n means n edges, table current.
// - One code drives all three sinks.
// - Edges up to 1 MHz accepted.
`timescale 1ns/10ps
module pulse_count_led_current_set
	import pulse_count_pkg::*;
#(
	parameter int unsigned LATCH_COUNT = LATCH_CYCLES,
	parameter int unsigned OFF_COUNT   = OFF_CYCLES
)
(
	input  wire logic           clk,
	input  wire logic           sys_rst,
	input  wire logic           en_data_pin,
	output      sink_drive_type sink_out_one,
	output      sink_drive_type sink_out_two,
	output      sink_drive_type sink_out_three,
	output      logic           shutdown
);
	import pulse_count_pkg::*;

	logic                 sync1_r;
	logic                 sync2_r;
	logic                 line_prev_r;
	link_state_type       state_r;
	link_state_type       state_nxt;
	logic [CODE_W-1:0]    count_r;
	logic [CODE_W-1:0]    count_nxt;
	logic [CODE_W-1:0]    applied_r;
	logic [CODE_W-1:0]    applied_nxt;
	logic [CODE_W-1:0]    applied_dly_r;
	logic [CODE_W-1:0]    applied_dly_nxt;
	logic [TIMER_W-1:0]   timer_r;
	logic [TIMER_W-1:0]   timer_nxt;
	logic                 rise;
	logic [CURRENT_W-1:0] table_current;
	sink_drive_type       drive_r;
	sink_drive_type       drive_nxt;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sync1_r     <= 1'b0;
			sync2_r     <= 1'b0;
			line_prev_r <= 1'b0;
		end
		else
		begin
			sync1_r     <= en_data_pin;
			sync2_r     <= sync1_r;
			line_prev_r <= sync2_r;
		end
	end

	assign rise = sync2_r & ~line_prev_r;

	// The timer counts cycles since the line last changed level.
	// It saturates at all ones, so a line that stays at one level for a
	// long time never wraps back and fires a timeout a second time.
	// Both timeouts are measured on the synchronised line, so they start
	// two cycles after the pin itself changes.
	always_comb
	begin
		state_nxt   = state_r;
		count_nxt   = count_r;
		applied_nxt = applied_r;
		timer_nxt   = timer_r;
		if (sync2_r != line_prev_r)
			timer_nxt = '0;
		else if (timer_r != {TIMER_W{1'b1}})
			timer_nxt = timer_r + 1'b1;
		case (state_r)
			ST_SHUTDOWN:
			begin
				if (rise)
				begin
					count_nxt = CODE_FIRST;
					state_nxt = ST_BURST;
				end
			end
			ST_BURST, ST_ACTIVE:
			begin
				if (rise)
				begin
					if (count_r >= CODE_LAST)
						count_nxt = CODE_FIRST;
					else
						count_nxt = count_r + 1'b1;
					state_nxt = ST_BURST;
				end
				else if (sync2_r && timer_r >= TIMER_W'(LATCH_COUNT - 1))
				begin
					applied_nxt = count_r;
					state_nxt   = ST_ACTIVE;
				end
				else if (!sync2_r && timer_r >= TIMER_W'(OFF_COUNT - 1))
				begin
					count_nxt   = CODE_RESET;
					applied_nxt = CODE_RESET;
					state_nxt   = ST_SHUTDOWN;
				end
			end
			default:
			begin
				state_nxt = ST_SHUTDOWN;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_r   <= ST_SHUTDOWN;
			count_r   <= CODE_RESET;
			applied_r <= CODE_RESET;
			timer_r   <= '0;
		end
		else
		begin
			state_r   <= state_nxt;
			count_r   <= count_nxt;
			applied_r <= applied_nxt;
			timer_r   <= timer_nxt;
		end
	end

	current_table u_table (
		.clk       (clk),
		.code      (applied_r),
		.current_r (table_current)
	);

	// Zero is the code that reset and shutdown leave behind.
	function automatic logic code_is_off(input logic [CODE_W-1:0] code_in);
		code_is_off = (code_in == CODE_RESET);
	endfunction

	// The code is delayed one cycle so that it reaches the drive register
	// together with the registered table current. Without this the sinks
	// would show the new code with the previous current for one cycle.
	always_comb
	begin
		applied_dly_nxt = applied_r;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			applied_dly_r <= CODE_RESET;
		else
			applied_dly_r <= applied_dly_nxt;
	end

	// The drive register follows the delayed code and the table together.
	always_comb
	begin
		drive_nxt.code    = applied_dly_r;
		drive_nxt.current = table_current;
		drive_nxt.enable  = !code_is_off(applied_dly_r);
		if (code_is_off(applied_dly_r))
			drive_nxt.current = '0;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			drive_r <= '0;
		else
			drive_r <= drive_nxt;
	end

	assign sink_out_one   = drive_r;
	assign sink_out_two   = drive_r;
	assign sink_out_three = drive_r;
	assign shutdown       = (state_r == ST_SHUTDOWN);

endmodule

// >>> verif/host_line_model.sv
// Host model that drives the single enable/data line with pulse bursts.
// Assumes a 100 MHz clk; the line changes just after each rising edge.
`timescale 1ns/10ps
module host_line_model
(
	input  wire logic clk,
	output      logic line
);
	initial line = 1'b0;
	// legal phases, hold high to latch
	task automatic burst(input int n);
		for (int i = 0; i < n; i++)
		begin
			line <= 1'b0;
			repeat (30) @(posedge clk);
			line <= 1'b1;
			repeat (6) @(posedge clk);
		end
	endtask
	task automatic go_low(input int cycles);
		line <= 1'b0;
		repeat (cycles) @(posedge clk);
	endtask
endmodule

// >>> verif/pulse_count_led_current_set_properties.sv
// Concurrent checks on the ports of the pulse-count current setter.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/10ps
module pulse_count_checker
	import pulse_count_pkg::*;
#(
	parameter int unsigned LATCH_COUNT = LATCH_CYCLES,
	parameter int unsigned OFF_COUNT   = OFF_CYCLES
)
(
	input wire logic           clk,
	input wire logic           sys_rst,
	input wire logic           en_data_pin,
	input wire sink_drive_type sink_out_one,
	input wire sink_drive_type sink_out_two,
	input wire sink_drive_type sink_out_three,
	input wire logic           shutdown
);
	logic [19:0] hi_r;
	logic [19:0] lo_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	always_ff @(posedge clk)
	begin
		hi_r <= (en_data_pin && !sys_rst) ? hi_r + 20'h1 : 20'h0;
		lo_r <= (!en_data_pin && !sys_rst) ? lo_r + 20'h1 : 20'h0;
	end
	chk_sinks_match: assert property (sink_out_one == sink_out_two && sink_out_one == sink_out_three)
		else $error("sink outputs differ");
	chk_shutdown_dark: assert property (shutdown [*3] |-> !sink_out_one.enable)
		else $error("sink on during shutdown");
	chk_wake_edge: assert property (shutdown && $rose(en_data_pin) |-> ##[1:5] !shutdown)
		else $error("no wake on first edge");
	chk_off_timeout: assert property (lo_r == OFF_COUNT + 6 |-> shutdown)
		else $error("no shutdown after long low");
	chk_code_range: assert property (sink_out_one.enable |-> sink_out_one.code inside {[1:32]})
		else $error("code out of range");
	chk_first_current: assert property (sink_out_one.enable && sink_out_one.code == CODE_FIRST |-> sink_out_one.current == 9'h12e)
		else $error("wrong current for first code");
	chk_latch_wait: assert property ($changed(sink_out_one) && sink_out_one.enable |-> hi_r >= LATCH_COUNT)
		else $error("setting applied before latch pause");
	chk_latch_apply: assert property (hi_r == LATCH_COUNT + 8 && !shutdown |-> sink_out_one.enable)
		else $error("setting not applied after latch pause");
endmodule
bind pulse_count_led_current_set pulse_count_checker #(.LATCH_COUNT(LATCH_COUNT), .OFF_COUNT(OFF_COUNT)) chk_u (.clk(clk), .sys_rst(sys_rst), .en_data_pin(en_data_pin), .sink_out_one(sink_out_one), .sink_out_two(sink_out_two), .sink_out_three(sink_out_three), .shutdown(shutdown));

// >>> verif/pulse_count_led_current_set_tb.sv
// Self-checking bench for the pulse-count current setter.
// Assumes short latch and off counts of 50 cycles.
`timescale 1ns/10ps
module pulse_count_led_current_set_tb;
	import pulse_count_pkg::*;
	localparam int unsigned LAT = 50;
	logic           clk;
	logic           sys_rst;
	logic           en_data_pin;
	sink_drive_type s1;
	sink_drive_type s2;
	sink_drive_type s3;
	logic           shutdown;
	int             mismatches = 0;
	int             cmp_count = 0;
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	host_line_model host_u (.clk(clk), .line(en_data_pin));
	pulse_count_led_current_set #(.LATCH_COUNT(LAT), .OFF_COUNT(LAT)) dut_u (.clk(clk),
		.sys_rst(sys_rst), .en_data_pin(en_data_pin), .sink_out_one(s1),
		.sink_out_two(s2), .sink_out_three(s3), .shutdown(shutdown));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic test_off;
		host_u.go_low(LAT + 10);
		check("shutdown", {15'h0, shutdown}, 16'h1);
		check("sink", s1, 16'h0);
		$display("test off done");
	endtask
	task automatic test_code(input int n, input logic [5:0] code, input logic [8:0] cur);
		int k;
		k = 0;
		test_off();
		host_u.burst(n);
		repeat (LAT / 2) @(posedge clk);
		check("early enable", {15'h0, s1.enable}, 16'h0);
		while (s1.enable !== 1'b1 && k < 2 * LAT)
		begin
			@(posedge clk);
			k++;
		end
		if (k == 2 * LAT)
		begin
			mismatches++;
			end_of_test();
		end
		repeat (2) @(posedge clk);
		check("code", {10'h0, s1.code}, {10'h0, code});
		check("current", {7'h0, s1.current}, {7'h0, cur});
		check("sink two", s2, s1);
		check("sink three", s3, s1);
		$display("test code %0d done", n);
	endtask
	initial
	begin
		sys_rst = 1'b1;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		check("reset sink", s1, 16'h0);
		test_code(1, CODE_FIRST, 9'h12e);
		test_code(16, 6'h10, 9'h09c);
		test_code(32, CODE_LAST, 9'h005);
		test_code(33, CODE_FIRST, 9'h12e);
		test_off();
		end_of_test();
	end
endmodule
